// ===== rtl/lcd_bus_if.sv
`timescale 1ns/1ns
interface lcd_bus_if;
  logic [3:0] value_bits;
  logic       digit_addr_low_bit;
  logic       digit_addr_high_bit;
  logic       select_strobe_a_n;
  logic       select_strobe_b_n;
  logic       osc_in_slave_sense;

  // host end drives the write strobes and data
  modport host (
    output value_bits,
    output digit_addr_low_bit,
    output digit_addr_high_bit,
    output select_strobe_a_n,
    output select_strobe_b_n,
    output osc_in_slave_sense
  );

  // decoder end only listens
  modport device (
    input value_bits,
    input digit_addr_low_bit,
    input digit_addr_high_bit,
    input select_strobe_a_n,
    input select_strobe_b_n,
    input osc_in_slave_sense
  );
endinterface : lcd_bus_if

// ===== rtl/lcd_decoder_pkg.sv
package lcd_decoder_pkg;

  // display geometry
  localparam int DIGIT_COUNT     = 4;
  localparam int SEG_COUNT       = 7;
  localparam int VALUE_WIDTH     = 4;
  localparam int ADDR_WIDTH      = 2;

  // oscillator to backplane divide ratio and nominal rates
  localparam int BP_DIVIDE       = 128;
  localparam int OSC_FREQ_HZ     = 19000;
  localparam int BP_FREQ_HZ      = 150;
  localparam int CLOCK_FREQ_HZ   = 20000000;

  // slave sense filter: low shorter than this is ignored
  localparam int SENSE_IGNORE_NS = 1000;
  localparam int CLOCK_PERIOD_NS = 1000000000 / CLOCK_FREQ_HZ;
  localparam int SENSE_CYCLES    = (SENSE_IGNORE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // internal oscillator half period in clock cycles (never longer than nominal, rounds down)
  localparam int OSC_HALF_CYCLES = CLOCK_FREQ_HZ / (2 * OSC_FREQ_HZ);

  // host strobe timing
  localparam int STROBE_LOW_NS   = 200;
  localparam int STROBE_GAP_NS   = 2000;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STROBE_GAP_CYC  = (STROBE_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // digit address codes
  localparam logic [1:0] ADDR_FOURTH = 2'h0;
  localparam logic [1:0] ADDR_THIRD  = 2'h1;
  localparam logic [1:0] ADDR_SECOND = 2'h2;
  localparam logic [1:0] ADDR_FIRST  = 2'h3;

  // segment order {g,f,e,d,c,b,a}
  localparam logic [6:0] SEG_BLANK = 7'h00;

  // value to segment image, dash and E H L P for ten to fourteen and blank for fifteen are in the table
  function automatic logic [6:0] seg_image(input logic [3:0] value);
    logic [6:0] img;
    img = SEG_BLANK;
    case (value)
      4'h0: img = 7'h3f;
      4'h1: img = 7'h06;
      4'h2: img = 7'h5b;
      4'h3: img = 7'h4f;
      4'h4: img = 7'h66;
      4'h5: img = 7'h6d;
      4'h6: img = 7'h7d;
      4'h7: img = 7'h07;
      4'h8: img = 7'h7f;
      4'h9: img = 7'h6f;
      4'ha: img = 7'h40; // dash
      4'hb: img = 7'h79; // E
      4'hc: img = 7'h76; // H
      4'hd: img = 7'h38; // L
      4'he: img = 7'h73; // P
      default: img = SEG_BLANK;
    endcase
    return img;
  endfunction : seg_image

  // address to digit slot (slot 0 is the first digit)
  function automatic logic [1:0] addr_to_slot(input logic [1:0] addr);
    return 2'h3 - addr;
  endfunction : addr_to_slot

endpackage : lcd_decoder_pkg

// ===== rtl/lcd_four_digit_decoder_driver.sv
`timescale 1ns/1ns
module lcd_four_digit_decoder_driver
  import lcd_decoder_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // host side
  lcd_bus_if.device        bus,
  // common plane pin, three signals
  input  wire logic        common_plane_in,
  output logic             common_plane_out,
  output logic             common_plane_oe_n,
  // segment drive, seven bits per digit, bit 0 is segment a
  output logic [6:0]       digit_first,
  output logic [6:0]       digit_second,
  output logic [6:0]       digit_third,
  output logic [6:0]       digit_fourth,
  // status
  output logic             slave_mode
);

  // three-stage pin synchronisers: strobes, sense, plane; data sampled inside the window
  logic [2:0] cs_a_sync_reg;
  logic [2:0] cs_b_sync_reg;
  logic [2:0] sense_sync_reg;
  logic [2:0] plane_sync_reg;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cs_a_sync_reg  <= 3'h7;
      cs_b_sync_reg  <= 3'h7;
      sense_sync_reg <= 3'h7;
      plane_sync_reg <= 3'h0;
    end
    else
    begin
      cs_a_sync_reg  <= {cs_a_sync_reg[1:0], bus.select_strobe_a_n};
      cs_b_sync_reg  <= {cs_b_sync_reg[1:0], bus.select_strobe_b_n};
      sense_sync_reg <= {sense_sync_reg[1:0], bus.osc_in_slave_sense};
      plane_sync_reg <= {plane_sync_reg[1:0], common_plane_in};
    end
  end

  // debounced levels change only when stages two and three agree
  logic cs_a_reg;
  logic cs_b_reg;
  logic sense_reg;
  logic plane_ext_reg;
  wire  cs_a_agree   = (cs_a_sync_reg[2] == cs_a_sync_reg[1]);
  wire  cs_b_agree   = (cs_b_sync_reg[2] == cs_b_sync_reg[1]);
  wire  sense_agree  = (sense_sync_reg[2] == sense_sync_reg[1]);
  wire  plane_agree  = (plane_sync_reg[2] == plane_sync_reg[1]);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cs_a_reg      <= 1'b1;
      cs_b_reg      <= 1'b1;
      sense_reg     <= 1'b1;
      plane_ext_reg <= 1'b0;
    end
    else
    begin
      if (cs_a_agree) cs_a_reg <= cs_a_sync_reg[2];
      if (cs_b_agree) cs_b_reg <= cs_b_sync_reg[2];
      if (sense_agree) sense_reg <= sense_sync_reg[2];
      if (plane_agree) plane_ext_reg <= plane_sync_reg[2];
    end
  end

  // input latches follow the pins while both strobes are low
  logic [3:0] value_latch_reg;
  logic [1:0] addr_latch_reg;
  wire        both_low   = ~cs_a_reg & ~cs_b_reg;
  wire  [3:0] value_pins = bus.value_bits;
  wire  [1:0] addr_pins  = {bus.digit_addr_high_bit, bus.digit_addr_low_bit};
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      value_latch_reg <= 4'hf;
      addr_latch_reg  <= 2'h0;
    end
    else if (both_low)
    begin
      value_latch_reg <= value_pins;
      addr_latch_reg  <= addr_pins;
    end
  end

  // commit on the first strobe rising out of the both-low window
  logic was_low_reg;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      was_low_reg <= 1'b0;
    else
      was_low_reg <= both_low;
  end
  wire        commit    = was_low_reg & ~both_low;
  wire  [1:0] slot      = addr_to_slot(addr_latch_reg);
  wire  [6:0] new_image = seg_image(value_latch_reg);

  // output latches, one per digit, blank after reset
  logic [6:0] image_reg [DIGIT_COUNT];
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DIGIT_COUNT; i++)
        image_reg[i] <= SEG_BLANK;
    end
    else if (commit)
      image_reg[slot] <= new_image;
  end

  // internal oscillator: toggles every OSC_HALF_CYCLES clocks
  localparam int OSC_W = $clog2(OSC_HALF_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_HALF_CYCLES - 1);
  logic [OSC_W-1:0] osc_cnt_reg;
  logic             osc_tick_reg;
  wire              osc_wrap = (osc_cnt_reg == OSC_LAST);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      osc_cnt_reg  <= '0;
      osc_tick_reg <= 1'b0;
    end
    else
    begin
      osc_cnt_reg  <= osc_wrap ? '0 : osc_cnt_reg + 1'b1;
      osc_tick_reg <= osc_wrap ? ~osc_tick_reg : osc_tick_reg;
    end
  end

  // divide oscillator by 128: bit 6 of a count of full oscillator periods
  logic [6:0] bp_div_reg;
  wire        osc_rise = osc_wrap & ~osc_tick_reg;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bp_div_reg <= 7'h00;
    else if (osc_rise)
      bp_div_reg <= bp_div_reg + 7'h01;
  end
  wire bp_internal = bp_div_reg[6];

  // slave sense filter: low must persist SENSE_CYCLES before slave mode is taken
  localparam int SF_W = $clog2(SENSE_CYCLES + 1);
  localparam logic [SF_W-1:0] SF_LIMIT = SF_W'(SENSE_CYCLES);
  logic [SF_W-1:0] sense_cnt_reg;
  wire             sense_full = (sense_cnt_reg == SF_LIMIT);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sense_cnt_reg <= '0;
    else if (sense_reg)
      sense_cnt_reg <= '0;
    else if (!sense_full)
      sense_cnt_reg <= sense_cnt_reg + 1'b1;
  end

  // plane selection and segment phase; all outputs registered
  wire       slave_next = sense_full;
  wire       plane_sel  = slave_next ? plane_ext_reg : bp_internal;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      slave_mode        <= 1'b0;
      common_plane_out  <= 1'b0;
      common_plane_oe_n <= 1'b0;
      digit_first       <= 7'h00;
      digit_second      <= 7'h00;
      digit_third       <= 7'h00;
      digit_fourth      <= 7'h00;
    end
    else
    begin
      slave_mode        <= slave_next;
      common_plane_out  <= bp_internal;
      common_plane_oe_n <= slave_next;
      digit_first       <= image_reg[0] ^ {SEG_COUNT{plane_sel}};
      digit_second      <= image_reg[1] ^ {SEG_COUNT{plane_sel}};
      digit_third       <= image_reg[2] ^ {SEG_COUNT{plane_sel}};
      digit_fourth      <= image_reg[3] ^ {SEG_COUNT{plane_sel}};
    end
  end

endmodule : lcd_four_digit_decoder_driver

// ===== rtl/lcd_host_writer.sv
`timescale 1ns/1ns
module lcd_host_writer
  import lcd_decoder_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // user request
  input  wire logic       wr_req,
  input  wire logic [3:0] wr_value,
  input  wire logic [1:0] wr_addr,
  input  wire logic       slave_request,
  output logic            wr_ready,
  output logic            wr_done,
  // link to decoder
  lcd_bus_if.host         bus
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_GAP  = 3'b100
  } host_state_t;

  // strobe low count plus extra margin for the three-stage synchroniser
  localparam int LOW_CYC = STROBE_LOW_CYC + 4;
  localparam int CNT_W   = $clog2(STROBE_GAP_CYC + LOW_CYC + 1);
  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(STROBE_GAP_CYC - 1);

  host_state_t      state_reg;
  host_state_t      state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0]       value_reg;
  logic [1:0]       addr_reg;

  // next state; gap honours minimum spacing between strobes
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (wr_req) state_next = ST_LOW;
      ST_LOW:  if (cnt_reg == LOW_LAST) state_next = ST_GAP;
      ST_GAP:  if (cnt_reg == GAP_LAST) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // both strobes move together so the pulse width always counts
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      value_reg <= 4'h0;
      addr_reg  <= 2'h0;
      wr_ready  <= 1'b0;
      wr_done   <= 1'b0;
      bus.value_bits          <= 4'h0;
      bus.digit_addr_low_bit  <= 1'b0;
      bus.digit_addr_high_bit <= 1'b0;
      bus.select_strobe_a_n   <= 1'b1;
      bus.select_strobe_b_n   <= 1'b1;
      bus.osc_in_slave_sense  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
      wr_ready  <= (state_next == ST_IDLE);
      wr_done   <= (state_reg == ST_LOW) && (state_next == ST_GAP);
      bus.osc_in_slave_sense <= ~slave_request;
      if (state_reg == ST_IDLE && wr_req)
      begin
        value_reg               <= wr_value;
        addr_reg                <= wr_addr;
        bus.value_bits          <= wr_value;
        bus.digit_addr_low_bit  <= wr_addr[0];
        bus.digit_addr_high_bit <= wr_addr[1];
      end
      bus.select_strobe_a_n <= ~(state_next == ST_LOW);
      bus.select_strobe_b_n <= ~(state_next == ST_LOW);
    end
  end

endmodule : lcd_host_writer

// ===== verification/lcd_decoder_props.sv
`timescale 1ns/1ns
module lcd_decoder_props
  import lcd_decoder_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // interface signals
  input wire logic [3:0] value_bits,
  input wire logic       digit_addr_low_bit,
  input wire logic       digit_addr_high_bit,
  input wire logic       select_strobe_a_n,
  input wire logic       select_strobe_b_n,
  input wire logic       osc_in_slave_sense,
  // decoder outputs
  input wire logic       common_plane_out,
  input wire logic       common_plane_oe_n,
  input wire logic [6:0] digit_first,
  input wire logic [6:0] digit_second,
  input wire logic [6:0] digit_third,
  input wire logic [6:0] digit_fourth,
  input wire logic       slave_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  wire       both_low = !select_strobe_a_n && !select_strobe_b_n;
  wire       both_up  = select_strobe_a_n && select_strobe_b_n;
  wire [27:0] cat     = {digit_first, digit_second, digit_third, digit_fourth};
  logic      up_prev_reg;
  logic [7:0] since_reg;
  logic [7:0] low_run_reg;

  // cycles since the strobes last went back up, saturating
  always_ff @(posedge clock)
  begin
    up_prev_reg <= both_up;
    if (sys_rst)
      since_reg <= 8'hff;
    else if (!up_prev_reg && both_up)
      since_reg <= 8'h00;
    else if (since_reg != 8'hff)
      since_reg <= since_reg + 8'h01;
  end

  // cycles the sense pin has stayed low, saturating
  always_ff @(posedge clock)
  begin
    if (sys_rst || osc_in_slave_sense)
      low_run_reg <= 8'h00;
    else if (low_run_reg != 8'hff)
      low_run_reg <= low_run_reg + 8'h01;
  end

  sequence seq_held_low;
    both_low [*8];
  endsequence
  sequence seq_released;
    both_up [*8];
  endsequence

  property p_strobe_pair;
    $fell(select_strobe_a_n) |-> !select_strobe_b_n;
  endproperty
  a_strobe_pair: assert property (p_strobe_pair) else $error("strobes not lowered together");
  property p_strobe_width;
    $fell(select_strobe_a_n) |-> seq_held_low ##1 both_up;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe low width wrong");
  property p_data_stable;
    both_low && $past(both_low) |-> $stable({value_bits, digit_addr_high_bit, digit_addr_low_bit});
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while selected");
  property p_strobe_gap;
    $rose(select_strobe_a_n) |-> seq_released;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobes lowered too soon");
  property p_slave_oe;
    low_run_reg >= 8'd30 |-> common_plane_oe_n && slave_mode;
  endproperty
  a_slave_oe: assert property (p_slave_oe) else $error("plane driven in slave mode");
  property p_master_oe;
    !slave_mode && !$past(slave_mode) |-> !common_plane_oe_n;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("plane not driven as master");
  property p_sense_filter;
    $rose(slave_mode) |-> !$past(osc_in_slave_sense, 3) && !$past(osc_in_slave_sense, 19);
  endproperty
  a_sense_filter: assert property (p_sense_filter) else $error("slave entered on short low");
  // plane edges also move the segments, so only quiet plane spans count
  property p_digit_hold;
    $changed(cat) && !slave_mode && !$past(slave_mode) && common_plane_out == $past(common_plane_out, 3)
      |-> since_reg <= 8'h0a;
  endproperty
  a_digit_hold: assert property (p_digit_hold) else $error("digit changed without a write");
endmodule : lcd_decoder_props

// ===== verification/tb_lcd_four_digit_decoder_driver.sv
`timescale 1ns/1ns
module tb_lcd_four_digit_decoder_driver
  import lcd_decoder_pkg::*;
;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       wr_req = 1'b0;
  logic [3:0] wr_value = 4'h0;
  logic [1:0] wr_addr = 2'h0;
  logic       slave_request = 1'b0;
  logic       common_plane_in = 1'b0;
  logic       wr_ready, wr_done, common_plane_out, common_plane_oe_n, slave_mode;
  logic [6:0] digit_first, digit_second, digit_third, digit_fourth;
  logic [27:0] exp_cat;
  int         num_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  // first oscillator rise comes half an oscillator period in, the plane flips on the 64th rise, plus out reg
  localparam int FIRST_PLANE_CYC = OSC_HALF_CYCLES * (BP_DIVIDE - 1) + 1;
  // images in {g..a} order, own copy kept apart from the design
  logic [6:0] img_tab [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                               7'h7f, 7'h6f, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
  wire [27:0] cat = {digit_first, digit_second, digit_third, digit_fourth};

  always #25 clock = ~clock;

  // cycles since reset release
  always @(posedge clock)
    cyc <= sys_rst ? 0 : cyc + 1;

  lcd_bus_if bus();
  lcd_host_writer i_lcd_host_writer (.clock(clock), .sys_rst(sys_rst), .wr_req(wr_req), .wr_value(wr_value),
    .wr_addr(wr_addr), .slave_request(slave_request), .wr_ready(wr_ready), .wr_done(wr_done), .bus(bus));
  lcd_four_digit_decoder_driver i_lcd_four_digit_decoder_driver (.clock(clock), .sys_rst(sys_rst), .bus(bus),
    .common_plane_in(common_plane_in), .common_plane_out(common_plane_out), .common_plane_oe_n(common_plane_oe_n),
    .digit_first(digit_first), .digit_second(digit_second), .digit_third(digit_third),
    .digit_fourth(digit_fourth), .slave_mode(slave_mode));
  lcd_decoder_props i_lcd_decoder_props (.clock(clock), .sys_rst(sys_rst), .value_bits(bus.value_bits),
    .digit_addr_low_bit(bus.digit_addr_low_bit), .digit_addr_high_bit(bus.digit_addr_high_bit),
    .select_strobe_a_n(bus.select_strobe_a_n), .select_strobe_b_n(bus.select_strobe_b_n),
    .osc_in_slave_sense(bus.osc_in_slave_sense), .common_plane_out(common_plane_out),
    .common_plane_oe_n(common_plane_oe_n), .digit_first(digit_first), .digit_second(digit_second),
    .digit_third(digit_third), .digit_fourth(digit_fourth), .slave_mode(slave_mode));

  task automatic chk(input logic [27:0] seen, input logic [27:0] want);
    tests_run++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  // one write, then wait out the gap so the next may follow at once
  task automatic write_digit(input logic [3:0] v, input logic [1:0] a);
    int n;
    n = 0;
    chk(28'(wr_ready), 28'h1);
    @(posedge clock);
    wr_req   <= 1'b1;
    wr_value <= v;
    wr_addr  <= a;
    @(posedge clock);
    wr_req <= 1'b0;
    while (n < 40 && wr_done !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(28'(n < 40), 28'h1);
    repeat (42) @(posedge clock);
    #1;
  endtask : write_digit

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    exp_cat = 28'h0;
    chk(cat, exp_cat);
    for (int v = 0; v < 16; v++)
    begin
      write_digit(v[3:0], v[1:0]);
      exp_cat[7 * (v % 4) +: 7] = img_tab[v];
      chk(cat, exp_cat);
    end
    // first backplane edge, counted from reset release
    wait (common_plane_out === 1'b1);
    chk(28'(cyc > FIRST_PLANE_CYC - 8 && cyc < FIRST_PLANE_CYC + 8), 28'h1);
    repeat (4) @(posedge clock);
    #1;
    chk(cat, ~exp_cat);
    @(posedge clock);
    slave_request <= 1'b1;
    repeat (15) @(posedge clock);
    slave_request <= 1'b0;
    repeat (30) @(posedge clock);
    #1;
    chk(28'({slave_mode, common_plane_oe_n}), 28'h0);
    @(posedge clock);
    slave_request <= 1'b1;
    repeat (40) @(posedge clock);
    #1;
    chk(28'({slave_mode, common_plane_oe_n}), 28'h3);
    chk(cat, exp_cat);
    @(posedge clock);
    common_plane_in <= 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk(cat, ~exp_cat);
    write_digit(4'hd, 2'h2);
    exp_cat[20:14] = img_tab[13];
    chk(cat, ~exp_cat);
    print_verdict();
  end

  // watchdog, about a third beyond one backplane half period
  initial
  begin
    repeat (90000) @(posedge clock);
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule : tb_lcd_four_digit_decoder_driver
